/* File: msp_board_model.sv */
// Board model: serial pins with pull-ups and the far bus party
module msp_board_model (
    input  logic scl_out,      // Design clock value
    input  logic scl_oe,       // Design clock drive
    input  logic sda_out,      // Design data value
    input  logic sda_oe,       // Design data drive
    input  logic host_scl_low, // Host pulls clock
    input  logic host_sda_low, // Host pulls data
    output logic scl_in,       // Clock wire
    output logic sda_in        // Data wire
);
    // Released wire goes to pull-up unless the far party pulls it low
    assign scl_in = scl_oe ? scl_out : !host_scl_low;
    assign sda_in = sda_oe ? sda_out : !host_sda_low;
endmodule

/* File: msp_checker.sv */
// Checker: cycle relations between the top-level pins
module msp_checker (
    input logic       clk_sys,           // Clock
    input logic       resetn,            // Reset, low
    input logic       perst_n,           // Fund. reset
    input logic       normal_mode_strap, // Strap
    input logic [3:0] pci_req_n,         // Requests
    input logic       power_event_in_n,  // Power event
    input logic       link_in_l2,        // Link in L2
    input logic [3:0] pci_clock_in,      // Clocks in
    input logic       clock_request_n,   // Core req
    input logic       clock_run_n,       // Core run
    input logic       sda_drive,         // Data value
    input logic       sda_drive_en,      // Data request
    input logic [3:0] gpio_oe_cfg,       // GPIO enables
    input logic [3:0] gpio_oe,           // GPIO drive
    input logic       scl_oe,            // Clock drive
    input logic       sda_out,           // Data out
    input logic       sda_oe,            // Data drive
    input logic [3:0] pci_clock_out,     // Clock pins
    input logic       wake_n,            // Wake
    input logic [1:0] mode,              // Mode
    input logic       cpm_enable,        // CPM on
    input logic       two_device_limit,  // Two devices
    input logic       strap_valid        // Captured
);
    logic [2:0] up_q;
    logic [2:0] up_d;
    logic       ok;
    // Outputs lag the synchroniser, so hold off a few edges
    always_comb up_d = (up_q == 3'h5) ? up_q : up_q + 3'h1;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) up_q <= 3'h0;
        else up_q <= up_d;
    end
    assign ok = (up_q == 3'h5);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    a_gpio_oe_follow: assert property (ok |-> gpio_oe == $past(gpio_oe_cfg))
        else $error("gpio enable wrong");
    a_scl_dir_mode: assert property (ok && $stable(mode) && mode != 2'h3
        |-> scl_oe == (mode == msp_pkg::MSP_MODE_EEPROM)) else $error("scl dir");
    a_sda_open_drain: assert property (ok && $stable(mode)
        && mode == msp_pkg::MSP_MODE_SMBUS |-> !sda_out
        && sda_oe == $past(sda_drive_en && !sda_drive)) else $error("sda drive");
    a_wake_from_event: assert property (ok |-> wake_n ==
        !$past(!power_event_in_n && link_in_l2)) else $error("wake wrong");
    a_strap_capture: assert property (ok && perst_n && !$past(perst_n)
        |=> strap_valid && cpm_enable == (!$past(normal_mode_strap)
        && $past(pci_req_n[3:2]) == 2'h0)) else $error("capture wrong");
    a_two_dev_limit: assert property (strap_valid
        |-> two_device_limit == cpm_enable) else $error("limit wrong");
    a_clk_req_pin: assert property (ok && cpm_enable && $past(cpm_enable, 2)
        |-> pci_clock_out[2] == $past(clock_request_n)) else $error("req pin");
    a_clk_run_pin: assert property (ok && cpm_enable && $past(cpm_enable, 2)
        |-> pci_clock_out[3] == $past(clock_run_n)) else $error("run pin");
    a_strap_held: assert property (strap_valid && $past(strap_valid)
        && $past(perst_n) |-> $stable(cpm_enable)) else $error("strap moved");
    c_cpm_on: cover property (strap_valid && cpm_enable);
    c_wake: cover property (ok && !wake_n);
    c_smbus: cover property (mode == msp_pkg::MSP_MODE_SMBUS && sda_oe);
endmodule
bind msp_mode_strap_pin_control msp_checker chk_u (.*);

/* File: msp_gpio_cell.sv */
// One general-purpose pin: registered output and output enable
module msp_gpio_cell (
    input  wire logic clk_sys,    // System clock
    input  wire logic rst_n,      // Synchronised reset, active low
    input  wire logic oe_cfg,     // Output enable from configuration
    input  wire logic out_cfg,    // Output value from configuration
    input  wire logic pin_in,     // Pin level
    output logic      pin_out,    // Pin drive value
    output logic      pin_oe,     // Pin drive enable
    output logic      in_value    // Registered pin level
);

    logic out_d;
    logic oe_d;
    logic in_d;
    logic out_q;
    logic oe_q;
    logic in_q;

    always_comb begin
        out_d = out_cfg;
        oe_d  = oe_cfg;    // [R1]
        in_d  = pin_in;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= 1'h0;
            oe_q  <= 1'h0;
            in_q  <= 1'h0;
        end else begin
            out_q <= out_d;
            oe_q  <= oe_d;
            in_q  <= in_d;
        end
    end

    assign pin_out  = out_q;
    assign pin_oe   = oe_q;
    assign in_value = in_q;

endmodule

/* File: msp_mode_strap_pin_control.sv */
// Top: mode straps, strap sampling, serial pins, GPIO and wake control
//
// Contract
// (R1) Four GPIO pins, each input-only or bidirectional via a configured enable.
// (R2) Bus select low drives serial clock out; high makes it an input.
// (R3) Serial data is push-pull bidirectional when low, open drain when high.
// (R4) Outside agent asserts power event low to request a power change.
// (R5) Wake output asserted while power event asserted and link in L2.
// (R6) Board holds both mode straps constant during operation.
// (R7) Both straps low: EEPROM mode, internal arbiter; select high: SMBus.
// (R8) Board ties normal-mode strap low; high is reserved.
// (R9) Normal-mode low: sample request pins 3 and 2 at reset release.
// (R10) Both sampled requests low: clock power management, two devices only.
// (R11) With it enabled, clock out 2 is clock request, 3 is clock run.
// (R12) Board keeps request pins 2 and 3 low for clock power management.
// (R13) Sampled straps held unchanged until the next reset assertion.
module msp_mode_strap_pin_control (
    input  wire logic        clk_sys,           // 40 MHz system clock
    input  wire logic        resetn,            // Async reset, active low
    input  wire logic        perst_n,           // Fundamental reset, active low
    input  wire logic        bus_select_strap,  // Strap: 0 EEPROM, 1 SMBus
    input  wire logic        normal_mode_strap, // Strap: 0 normal
    input  wire logic [3:0]  pci_req_n,         // PCI request pins
    input  wire logic        power_event_in_n,  // Power event, active low
    input  wire logic        link_in_l2,        // Link is in L2
    input  wire logic [3:0]  pci_clock_in,      // Internal PCI clocks
    input  wire logic        clock_request_n,   // Clock request from core
    input  wire logic        clock_run_n,       // Clock run from core
    input  wire logic        scl_drive,         // Master clock drive value
    input  wire logic        sda_drive,         // Data drive value
    input  wire logic        sda_drive_en,      // Data drive request
    input  wire logic        scl_in,            // Serial clock pin level
    input  wire logic        sda_in,            // Serial data pin level
    input  wire logic [3:0]  gpio_oe_cfg,       // GPIO output enables
    input  wire logic [3:0]  gpio_out_cfg,      // GPIO output values
    input  wire logic [3:0]  gpio_in,           // GPIO pin levels
    output logic [3:0]       gpio_out,          // GPIO drive values
    output logic [3:0]       gpio_oe,           // GPIO drive enables
    output logic [3:0]       gpio_value,        // GPIO sampled levels
    output logic             scl_out,           // Serial clock drive value
    output logic             scl_oe,            // Serial clock drive enable
    output logic             sda_out,           // Serial data drive value
    output logic             sda_oe,            // Serial data drive enable
    output logic             scl_value,         // Registered clock level
    output logic             sda_value,         // Registered data level
    output logic [3:0]       pci_clock_out,     // PCI clock pins
    output logic             wake_n,            // Wake, active low
    output logic [1:0]       mode,              // Decoded mode
    output logic             cpm_enable,        // Clock power management on
    output logic             two_device_limit,  // Only two secondary devices
    output logic             strap_valid        // Straps captured
);

    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= msp_pkg::SYNC_RESET;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'h1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // Strap capture on fundamental reset release
    logic                  perst_q;
    logic                  perst_d;
    msp_pkg::msp_strap_type strap_q;
    msp_pkg::msp_strap_type strap_d;
    logic                  release_evt;
    logic [1:0]            req_strap;

    always_comb begin
        req_strap   = pci_req_n[msp_pkg::REQ_STRAP_HI:msp_pkg::REQ_STRAP_LO];
        release_evt = perst_n && !perst_q;
        perst_d     = perst_n;
        strap_d     = strap_q;
        if (!perst_n) begin
            strap_d = '0;    // [R13]
        end else if (release_evt && !strap_q.valid) begin
            strap_d.valid       = 1'h1;
            strap_d.bus_select  = bus_select_strap;
            strap_d.normal_mode = normal_mode_strap;
            // Reserved mode skips request strap sampling
            strap_d.cpm_enable  = !normal_mode_strap
                && (req_strap == msp_pkg::CPM_STRAP_MATCH);  // [R9] [R10]
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            perst_q <= 1'h0;
            strap_q <= '0;
        end else begin
            perst_q <= perst_d;
            strap_q <= strap_d;    // [R13]
        end
    end

    // Live straps until capture; board keeps them steady anyway
    logic                        sel_eff;
    logic                        nrm_eff;
    msp_pkg::msp_serial_pins_type ser_d;
    msp_pkg::msp_serial_pins_type ser_q;
    logic [1:0]                  mode_d;
    logic [1:0]                  mode_q;

    always_comb begin
        sel_eff = strap_q.valid ? strap_q.bus_select : bus_select_strap;
        nrm_eff = strap_q.valid ? strap_q.normal_mode : normal_mode_strap;
        if (nrm_eff) begin
            mode_d = msp_pkg::MSP_MODE_RESERVED;
        end else if (sel_eff) begin
            mode_d = msp_pkg::MSP_MODE_SMBUS;    // [R7]
        end else begin
            mode_d = msp_pkg::MSP_MODE_EEPROM;   // [R7]
        end
        if (!sel_eff) begin
            ser_d.scl_out = scl_drive;    // [R2]
            ser_d.scl_oe  = 1'h1;         // [R2]
            ser_d.sda_out = sda_drive;    // [R3]
            ser_d.sda_oe  = sda_drive_en; // [R3]
        end else begin
            ser_d.scl_out = 1'h0;
            ser_d.scl_oe  = 1'h0;         // [R2]
            // Open drain: only ever pull low
            ser_d.sda_out = 1'h0;                        // [R3]
            ser_d.sda_oe  = sda_drive_en && !sda_drive;  // [R3]
        end
    end

    // Clock pin repurposing and wake
    logic [3:0] clk_d;
    logic [3:0] clk_q;
    logic       wake_d;
    logic       wake_q;
    logic       scl_v_q;
    logic       sda_v_q;

    always_comb begin
        clk_d = pci_clock_in;
        if (strap_q.cpm_enable) begin
            clk_d[msp_pkg::CLK_REQ_IDX] = clock_request_n;  // [R11]
            clk_d[msp_pkg::CLK_RUN_IDX] = clock_run_n;      // [R11]
        end
        wake_d = !(!power_event_in_n && link_in_l2);        // [R5] [R4]
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ser_q   <= '0;
            mode_q  <= msp_pkg::MSP_MODE_EEPROM;
            clk_q   <= 4'h0;
            wake_q  <= 1'h1;
            scl_v_q <= 1'h1;
            sda_v_q <= 1'h1;
        end else begin
            ser_q   <= ser_d;
            mode_q  <= mode_d;
            clk_q   <= clk_d;
            wake_q  <= wake_d;
            scl_v_q <= scl_in;
            sda_v_q <= sda_in;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < msp_pkg::GPIO_COUNT; gi++) begin : g_gpio
            msp_gpio_cell u_cell (
                .clk_sys  (clk_sys),
                .rst_n    (rst_n),
                .oe_cfg   (gpio_oe_cfg[gi]),
                .out_cfg  (gpio_out_cfg[gi]),
                .pin_in   (gpio_in[gi]),
                .pin_out  (gpio_out[gi]),
                .pin_oe   (gpio_oe[gi]),
                .in_value (gpio_value[gi])
            );
        end
    endgenerate

    assign scl_out          = ser_q.scl_out;
    assign scl_oe           = ser_q.scl_oe;
    assign sda_out          = ser_q.sda_out;
    assign sda_oe           = ser_q.sda_oe;
    assign scl_value        = scl_v_q;
    assign sda_value        = sda_v_q;
    assign pci_clock_out    = clk_q;
    assign wake_n           = wake_q;
    assign mode             = mode_q;
    assign cpm_enable       = strap_q.cpm_enable;
    assign two_device_limit = strap_q.cpm_enable;   // [R10]
    assign strap_valid      = strap_q.valid;

endmodule

/* File: msp_pkg.sv */
// Package: constants and carrier types for the mode strap and pin control
package msp_pkg;

    localparam int GPIO_COUNT       = 4;
    localparam int PCI_CLOCK_OUT_COUNT     = 4;
    localparam int REQ_STRAP_LO     = 2;
    localparam int REQ_STRAP_HI     = 3;
    localparam int CLK_REQ_IDX      = 2;
    localparam int CLK_RUN_IDX      = 3;
    localparam int STRAP_PIPE_WIDTH = 2;

    localparam logic [1:0] CPM_STRAP_MATCH = 2'h0;
    localparam logic [3:0] GPIO_OE_RESET   = 4'h0;
    localparam logic [1:0] SYNC_RESET      = 2'h0;

    typedef enum logic [1:0] {
        MSP_MODE_EEPROM   = 2'h0,
        MSP_MODE_SMBUS    = 2'h1,
        MSP_MODE_RESERVED = 2'h3
    } msp_mode_type;

    // Strap values held from the end of fundamental reset
    typedef struct packed {
        logic         valid;
        logic         cpm_enable;
        logic         bus_select;
        logic         normal_mode;
    } msp_strap_type;

    // Serial bus pin drive: output, output enable
    typedef struct packed {
        logic         scl_out;
        logic         scl_oe;
        logic         sda_out;
        logic         sda_oe;
    } msp_serial_pins_type;

endpackage

/* File: tb_mode_strap_pin_control.sv */
// Testbench: strap capture, pin control and wake
module tb_mode_strap_pin_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 0, resetn = 0, perst_n = 0, bus_select_strap = 0;
    logic normal_mode_strap = 0, power_event_in_n = 1, link_in_l2 = 0;
    logic clock_request_n = 1, clock_run_n = 1, scl_drive = 1;
    logic sda_drive = 1, sda_drive_en = 0, scl_in, sda_in, hs = 0, hd = 0;
    logic [3:0] pci_req_n = 0, pci_clock_in = 0, gpio_oe_cfg = 0;
    logic [3:0] gpio_out_cfg = 0, gpio_in = 0, go, ge, gv, pco;
    logic scl_out, scl_oe, sda_out, sda_oe, sv, dv, wk, cpm, tdl, stv;
    logic [1:0] mode;
    logic [3:0] exp_q[$];
    logic [22:0] pin_q[$];
    logic cpm_exp = 0;
    int miscompares = 0, cmp_count = 0;
    always #12.5 clk_sys = ~clk_sys;
    msp_mode_strap_pin_control dut_u (.clk_sys(clk_sys), .resetn(resetn),
        .perst_n(perst_n), .bus_select_strap(bus_select_strap),
        .normal_mode_strap(normal_mode_strap), .pci_req_n(pci_req_n),
        .power_event_in_n(power_event_in_n), .link_in_l2(link_in_l2),
        .pci_clock_in(pci_clock_in), .clock_request_n(clock_request_n),
        .clock_run_n(clock_run_n), .scl_drive(scl_drive),
        .sda_drive(sda_drive), .sda_drive_en(sda_drive_en),
        .scl_in(scl_in), .sda_in(sda_in), .gpio_oe_cfg(gpio_oe_cfg),
        .gpio_out_cfg(gpio_out_cfg), .gpio_in(gpio_in), .gpio_out(go),
        .gpio_oe(ge), .gpio_value(gv), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_out(sda_out), .sda_oe(sda_oe), .scl_value(sv),
        .sda_value(dv), .pci_clock_out(pco), .wake_n(wk), .mode(mode),
        .cpm_enable(cpm), .two_device_limit(tdl), .strap_valid(stv));
    msp_board_model board_u (.scl_out(scl_out), .scl_oe(scl_oe),
        .sda_out(sda_out), .sda_oe(sda_oe), .host_scl_low(hs),
        .host_sda_low(hd), .scl_in(scl_in), .sda_in(sda_in));
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk_strap(input logic [3:0] e, input logic [3:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t strap %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_pins(input logic [22:0] e, input logic [22:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t pins %h exp %h", $time, g, e);
        end
    endtask
    // Random traffic on every live input, incl. power event agent
    // Each note is queued one edge later, when the design has taken it
    task automatic noise(input int n);
        logic [15:0] g;
        logic [3:0]  v;
        logic [3:0]  p;
        logic [2:0]  c;
        logic [1:0]  s;
        logic [22:0] e;
        logic        have;
        have = 0;
        e = '0;
        repeat (n) begin
            @(posedge clk_sys);
            if (have) pin_q.push_back(e);
            g = 16'($urandom);
            v = 4'($urandom);
            c = 3'($urandom);
            s = 2'($urandom);
            {gpio_oe_cfg, gpio_out_cfg, gpio_in, pci_clock_in} <= g;
            {power_event_in_n, link_in_l2, hs, hd} <= v;
            {clock_request_n, clock_run_n, scl_drive} <= c;
            {sda_drive, sda_drive_en} <= s;
            p = g[3:0];
            if (cpm_exp) begin
                p[2] = c[2];
                p[3] = c[1];
            end
            e = {!(!v[3] && v[2]), g[11:8], g[15:12], g[7:4],
                 bus_select_strap ? 1'b0 : c[0], !bus_select_strap,
                 bus_select_strap ? 1'b0 : s[1],
                 bus_select_strap ? (s[0] && !s[1]) : s[0],
                 p, cpm_exp, cpm_exp};
            have = 1;
        end
        @(posedge clk_sys);
        if (have) pin_q.push_back(e);
    endtask
    // Straps are set while fundamental reset is low; request pins flip again after capture
    task automatic cap(input logic nm, input logic bs, input logic [1:0] rq);
        int n;
        perst_n <= 0;
        repeat (3) @(posedge clk_sys);
        {normal_mode_strap, bus_select_strap} <= {nm, bs};
        pci_req_n <= {rq, 2'($urandom)};
        @(posedge clk_sys);
        perst_n <= 1;
        exp_q.push_back({{2{!nm && rq == 2'h0}}, nm ? 2'h3 : {1'b0, bs}});
        cpm_exp = !nm && rq == 2'h0;
        n = 0;
        while (stv !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1 n++;
        end
        if (n == 20) begin
            miscompares++;
            tally_and_finish();
        end
        pci_req_n <= ~pci_req_n;
        noise(30);
    endtask
    always begin
        @(posedge stv);
        @(posedge clk_sys);
        #1 if (exp_q.size() > 0)
            chk_strap(exp_q.pop_front(), {cpm, tdl, mode});
    end
    always @(posedge clk_sys) begin
        #1 if (pin_q.size() > 0)
            chk_pins(pin_q.pop_front(), {wk, go, ge, gv, scl_out, scl_oe,
                sda_out, sda_oe, pco, cpm, tdl});
    end
    initial begin
        void'($urandom(32'h875B));
        repeat (3) @(posedge clk_sys);
        resetn <= 1;
        repeat (4) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) cap(i == 7, i[0], i[2:1]);
        $display("test strap table done");
        // Let the last pin compare see settled outputs before reset
        repeat (2) @(posedge clk_sys);
        resetn <= 0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1;
        cap(1'b0, 1'b1, 2'h0);
        cap(1'b0, 1'b0, 2'h0);
        $display("test reset rerun done");
        tally_and_finish();
    end
endmodule
